// [logic/fbas_device.sv]
// device end: page buffer, checksum commit and security levels
//
// Overview of operation
// - pas 0x00 maps general memory into buffer
// - buffer bytes at codes 0x40..0x5f
// - single bytes indexed by offset, no full transfer
// - commit only on correct checksum at 0x60
// - page select picks 32-byte page of class
// - host selects class before page when unlocked
// - short writes leave later bytes untouched
// - stored values never range checked
// - info block is class 58 when general
// - locked or pas nonzero: pages 1..3 pick blocks
// - correct checksum writes info block back
// - block A read-only while locked
// - access permissions per security level
// - boot entry and key writes need full access
// - key words consecutive, other control word cancels
// - keys differ from every subcommand code
// - locked bit clears on unlock key pair
// - full access bit clears on full key pair
// - two-word keys, changeable only in full access
// - key words compared as stored, not byte-swapped
// - direct reads work locked and unlocked
// - pas 0x01 gives locked page select behaviour
// - checksum covers the 32 buffer bytes
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module fbas_device #(
  parameter int NV_CLASSES = 64,
  parameter int NV_PAGES   = 4
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  fbas_link_if.dev                   LINK,
  output      fbas_pkg::fbas_sec_type SEC_STATE,
  output      logic                  NV_COMMIT
);
  localparam int NV_DEPTH = NV_CLASSES * NV_PAGES;

  if (NV_CLASSES < 64 || NV_CLASSES > 256 || NV_PAGES < 4 ||
      NV_PAGES > 256)
    $error("fbas_device: memory shape out of range");

  typedef struct packed {
    logic        ok_rd;
    logic        ok_wr;
    logic [15:0] idx;
  } fbas_sel_type;

  typedef struct packed {
    fbas_pkg::fbas_sec_type sec;
    logic                   key_armed;
    logic [7:0]             ctrl_lo;
    logic [7:0]             pas;
    logic [7:0]             cls;
    logic [7:0]             page;
    logic [31:0][7:0]       buf_b;
    logic [5:0]             wlen;
    logic [7:0]             csum;
    fbas_sel_type           sel;
    logic                   rsp_v;
    logic [7:0]             rsp_d;
    logic                   commit;
  } fbas_dev_type;

  fbas_dev_type st_r;
  fbas_dev_type st_nxt;
  logic [255:0] nv_mem [NV_DEPTH];
  logic         wr_commit;
  logic [31:0]  wr_mask;

  // translate selection into a memory page and its permissions
  function automatic fbas_sel_type map_sel(fbas_pkg::fbas_sec_type s,
                                           logic [7:0] pas,
                                           logic [7:0] cls,
                                           logic [7:0] pg);
    fbas_sel_type r;
    logic         mib;
    logic [7:0]   c;
    logic [7:0]   p;
    // locked or nonzero pas selects info blocks
    mib = (s == fbas_pkg::SEC_LOCKED) || (pas != fbas_pkg::PAS_GENERAL);
    // block A lives at class 58 page 0
    c = mib ? fbas_pkg::MIB_CLASS : cls;
    p = mib ? pg - fbas_pkg::MIB_FIRST : pg;
    // boot mode reaches nothing, locked only info blocks
    r.ok_rd = (s != fbas_pkg::SEC_BOOT) && (int'(c) < NV_CLASSES) &&
              (int'(p) < NV_PAGES) &&
              (!mib || (pg >= fbas_pkg::MIB_FIRST &&
                        pg <= fbas_pkg::MIB_LAST));
    // key page writable in full access only
    r.ok_wr = r.ok_rd && !(c == fbas_pkg::KEY_CLASS &&
                           s != fbas_pkg::SEC_FULL);
    if (s == fbas_pkg::SEC_LOCKED && pg == fbas_pkg::MIB_FIRST)
      r.ok_wr = 1'b0;
    r.idx = 16'(int'(c) * NV_PAGES + int'(p));
    return r;
  endfunction

  logic [255:0] key_page;
  logic [255:0] dcap_page;
  assign key_page  = nv_mem[int'(fbas_pkg::KEY_CLASS) * NV_PAGES];
  assign dcap_page = nv_mem[int'(fbas_pkg::DCAP_CLASS) * NV_PAGES];

  // next-state logic for every command on the link
  always_comb begin
    logic [7:0]  sum;
    logic [15:0] word;
    logic [4:0]  off;
    logic        lvl_ok;
    logic [15:0] k0;
    logic [15:0] k1;
    logic [15:0] cs_word;
    logic [15:0] fl_word;
    fbas_sel_type live;
    logic        acc_rd;
    logic        acc_wr;
    sum     = 8'h00;
    word    = {LINK.req_wdata, st_r.ctrl_lo};
    off     = LINK.req_code[4:0];
    lvl_ok  = 1'b0;
    k0      = 16'h0000;
    k1      = 16'h0000;
    cs_word = 16'h0000;
    fl_word = 16'h0000;
    // rights follow the level held now, not the one at select
    live    = map_sel(st_r.sec, st_r.pas, st_r.cls, st_r.page);
    acc_rd  = st_r.sel.ok_rd && live.ok_rd && live.idx == st_r.sel.idx;
    acc_wr  = acc_rd && live.ok_wr;
    st_nxt  = st_r;
    st_nxt.rsp_v  = 1'b0;
    st_nxt.commit = 1'b0;
    wr_commit = 1'b0;
    wr_mask   = 32'h0000_0000;
    // sum runs over all 32 buffer bytes
    for (int i = 0; i < fbas_pkg::PAGE_BYTES; i++)
      sum = sum + st_r.buf_b[i];
    // expected words are the stored words in their stored byte order
    if (st_r.sec == fbas_pkg::SEC_LOCKED) begin
      lvl_ok = 1'b1;
      k0 = {key_page[15:8], key_page[7:0]};
      k1 = {key_page[31:24], key_page[23:16]};
    end else if (st_r.sec == fbas_pkg::SEC_UNLOCKED) begin
      lvl_ok = 1'b1;
      k0 = {key_page[47:40], key_page[39:32]};
      k1 = {key_page[63:56], key_page[55:48]};
    end
    cs_word[fbas_pkg::CS_LOCKED_BIT] = (st_r.sec == fbas_pkg::SEC_LOCKED);
    fl_word[fbas_pkg::FL_FAS_BIT]    = (st_r.sec != fbas_pkg::SEC_FULL);
    if (LINK.req_valid && LINK.req_write) begin
      case (LINK.req_code) inside
        fbas_pkg::CODE_CTRL_LO: st_nxt.ctrl_lo = LINK.req_wdata;
        fbas_pkg::CODE_CTRL_HI: begin
          // second key must be the next control word after the first
          st_nxt.key_armed = lvl_ok && !st_r.key_armed && word == k0;
          if (lvl_ok && st_r.key_armed && word == k1) begin
            // unlock pair clears the locked bit
            // full pair clears the full access bit
            st_nxt.sec = (st_r.sec == fbas_pkg::SEC_LOCKED) ?
                         fbas_pkg::SEC_UNLOCKED : fbas_pkg::SEC_FULL;
          end else if (!st_nxt.key_armed) begin
            if (word == fbas_pkg::SUB_SEAL &&
                st_r.sec != fbas_pkg::SEC_BOOT)
              st_nxt.sec = fbas_pkg::SEC_LOCKED;
            // only full access may jump to boot mode
            if (word == fbas_pkg::SUB_ROM && st_r.sec == fbas_pkg::SEC_FULL)
              st_nxt.sec = fbas_pkg::SEC_BOOT;
            if (word == fbas_pkg::SUB_ROM_EXIT &&
                st_r.sec == fbas_pkg::SEC_BOOT)
              st_nxt.sec = fbas_pkg::SEC_LOCKED;
          end
        end
        // class select ignored while locked or in boot
        fbas_pkg::CODE_CLASS: begin
          if (st_r.sec == fbas_pkg::SEC_UNLOCKED ||
              st_r.sec == fbas_pkg::SEC_FULL)
            st_nxt.cls = LINK.req_wdata;
        end
        // page select loads the chosen page
        fbas_pkg::CODE_PAGE: begin
          st_nxt.page = LINK.req_wdata;
          st_nxt.sel  = map_sel(st_r.sec, st_r.pas, st_r.cls,
                                LINK.req_wdata);
          st_nxt.wlen = 6'h00;
          st_nxt.buf_b = st_nxt.sel.ok_rd ?
                         nv_mem[int'(st_nxt.sel.idx)] : '0;
        end
        // pas 0x00 general, 0x01 info blocks
        fbas_pkg::CODE_PAS: st_nxt.pas = LINK.req_wdata;
        // one byte at its offset, rest of buffer kept
        [fbas_pkg::CODE_BUF:fbas_pkg::CODE_BUF_LAST]: begin
          if (acc_rd) begin
            st_nxt.buf_b[off] = LINK.req_wdata;
            // remember how far the page was written
            if ({1'b0, off} >= st_r.wlen)
              st_nxt.wlen = 6'({1'b0, off} + 6'h01);
          end
        end
        fbas_pkg::CODE_CSUM: begin
          st_nxt.csum = LINK.req_wdata;
          // commit only on a matching checksum
          // expected value is 255 minus the byte sum
          if (acc_wr &&
              LINK.req_wdata == 8'(fbas_pkg::CSUM_BASE - sum)) begin
            // info block written back like any page
            wr_commit     = 1'b1;
            st_nxt.commit = 1'b1;
            for (int i = 0; i < fbas_pkg::PAGE_BYTES; i++)
              wr_mask[i] = (i < int'(st_r.wlen));
          end
        end
        default: ;
      endcase
    end
    if (LINK.req_valid && !LINK.req_write) begin
      st_nxt.rsp_v = 1'b1;
      case (LINK.req_code) inside
        fbas_pkg::CODE_CTRL_LO:  st_nxt.rsp_d = cs_word[7:0];
        fbas_pkg::CODE_CTRL_HI:  st_nxt.rsp_d = cs_word[15:8];
        fbas_pkg::CODE_FLAGS_LO: st_nxt.rsp_d = fl_word[7:0];
        fbas_pkg::CODE_FLAGS_HI: st_nxt.rsp_d = fl_word[15:8];
        // direct reads served in locked and unlocked
        fbas_pkg::CODE_DCAP_LO:  st_nxt.rsp_d = dcap_page[7:0];
        fbas_pkg::CODE_DCAP_HI:  st_nxt.rsp_d = dcap_page[15:8];
        fbas_pkg::CODE_CLASS:    st_nxt.rsp_d = st_r.cls;
        fbas_pkg::CODE_PAGE:     st_nxt.rsp_d = st_r.page;
        fbas_pkg::CODE_CSUM:     st_nxt.rsp_d = st_r.csum;
        fbas_pkg::CODE_PAS:      st_nxt.rsp_d = st_r.pas;
        [fbas_pkg::CODE_BUF:fbas_pkg::CODE_BUF_LAST]:
          st_nxt.rsp_d = acc_rd ? st_r.buf_b[off] : 8'h00;
        default:                 st_nxt.rsp_d = 8'h00;
      endcase
    end
  end

  // state register; locked with nothing selected after reset
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r     <= '0;
      st_r.sec <= fbas_pkg::SEC_LOCKED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // committed bytes stored as written, no bounds
  always_ff @(posedge CLK) begin
    if (wr_commit) begin
      for (int i = 0; i < fbas_pkg::PAGE_BYTES; i++)
        if (wr_mask[i])
          nv_mem[int'(st_r.sel.idx)][8*i +: 8] <= st_r.buf_b[i];
    end
  end

  assign LINK.rsp_valid = st_r.rsp_v;
  assign LINK.rsp_data  = st_r.rsp_d;
  assign SEC_STATE      = st_r.sec;
  assign NV_COMMIT      = st_r.commit; // one cycle after good checksum
endmodule // fbas_device

// [logic/fbas_pkg.sv]
// constants and types shared by both ends of the page access link
package fbas_pkg;
  // command codes seen on the link, and page size
  localparam logic [7:0] CODE_CTRL_LO  = 8'h00;
  localparam logic [7:0] CODE_CTRL_HI  = 8'h01;
  localparam logic [7:0] CODE_FLAGS_LO = 8'h0e;
  localparam logic [7:0] CODE_FLAGS_HI = 8'h0f;
  localparam logic [7:0] CODE_DCAP_LO  = 8'h3c;
  localparam logic [7:0] CODE_DCAP_HI  = 8'h3d;
  localparam logic [7:0] CODE_CLASS    = 8'h3e;
  localparam logic [7:0] CODE_PAGE     = 8'h3f;
  localparam logic [7:0] CODE_BUF      = 8'h40;
  localparam logic [7:0] CODE_BUF_LAST = 8'h5f;
  localparam logic [7:0] CODE_CSUM     = 8'h60;
  localparam logic [7:0] CODE_PAS      = 8'h61;
  localparam int         PAGE_BYTES    = 32;
  // page access select values
  localparam logic [7:0] PAS_GENERAL   = 8'h00;
  localparam logic [7:0] PAS_MIB       = 8'h01;
  // memory layout and checksum base
  localparam logic [7:0] MIB_CLASS     = 8'h3a;
  localparam logic [7:0] MIB_FIRST     = 8'h01;
  localparam logic [7:0] MIB_LAST      = 8'h03;
  localparam logic [7:0] KEY_CLASS     = 8'h3f;
  localparam logic [7:0] DCAP_CLASS    = 8'h30;
  localparam logic [7:0] CSUM_BASE     = 8'hff;
  // control subcommands and status bit positions
  localparam logic [15:0] SUB_SEAL     = 16'h0020;
  localparam logic [15:0] SUB_ROM      = 16'h0f00;
  localparam logic [15:0] SUB_ROM_EXIT = 16'h0f01;
  localparam int          CS_LOCKED_BIT = 13;
  localparam int          FL_FAS_BIT    = 14;
  // host register offsets and bit positions
  localparam logic [7:0] HREG_CMD      = 8'h00;
  localparam logic [7:0] HREG_SETUP    = 8'h04;
  localparam logic [7:0] HREG_KEY      = 8'h08;
  localparam logic [7:0] HREG_STATUS   = 8'h0c;
  localparam int         HCMD_WR_BIT   = 16;
  localparam int         HSET_SKIP_BIT = 24;

  typedef enum logic [1:0] {
    SEC_LOCKED, SEC_UNLOCKED, SEC_FULL, SEC_BOOT
  } fbas_sec_type;
endpackage

// [logic/fbas_link_if.sv]
// byte command link between host controller and device
`timescale 1ns/100ps
interface fbas_link_if;
  logic       req_valid;
  logic       req_write;
  logic [7:0] req_code;
  logic [7:0] req_wdata;
  logic       rsp_valid;
  logic [7:0] rsp_data;

  modport dev  (input  req_valid, req_write, req_code, req_wdata,
                output rsp_valid, rsp_data);
  modport host (output req_valid, req_write, req_code, req_wdata,
                input  rsp_valid, rsp_data);
endinterface

// [logic/fbas_host.sv]
// host end: APB registers driving command sequences onto the link
`timescale 1ns/100ps
module fbas_host (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output      logic [31:0] PRDATA,
  output      logic        PREADY,
  output      logic        PSLVERR,
  fbas_link_if.host        LINK
);
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_WAIT} fbas_hst_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] code;
    logic [7:0] data;
  } fbas_op_type;

  typedef struct packed {
    fbas_hst_type          state;
    fbas_op_type [3:0]     ops;
    logic [2:0]            cnt;
    logic [2:0]            idx;
    fbas_op_type           req;
    logic                  req_v;
    logic [7:0]            rdata;
    logic [31:0][7:0]      shadow;
    logic [31:0]           prdata;
  } fbas_host_type;

  fbas_host_type st_r;
  fbas_host_type st_nxt;

  always_comb begin
    logic       wr_acc;
    logic [7:0] sum;
    wr_acc = PSEL && PENABLE && PWRITE && st_r.state == HS_IDLE;
    sum    = 8'h00;
    st_nxt = st_r;
    st_nxt.req_v = 1'b0;
    // checksum of what the host saw in the buffer
    for (int i = 0; i < fbas_pkg::PAGE_BYTES; i++)
      sum = sum + st_r.shadow[i];
    // register read data captured in the setup cycle
    if (PSEL && !PENABLE && !PWRITE) begin
      st_nxt.prdata = 32'h0000_0000;
      if (PADDR == fbas_pkg::HREG_STATUS)
        st_nxt.prdata = {8'h00, 8'(fbas_pkg::CSUM_BASE - sum),
                         st_r.rdata, 7'h00, st_r.state != HS_IDLE};
    end
    // writes while busy are dropped, software polls status
    if (wr_acc) begin
      st_nxt.idx = 3'h0;
      case (PADDR)
        fbas_pkg::HREG_CMD: begin
          st_nxt.ops[0] = {PWDATA[fbas_pkg::HCMD_WR_BIT], PWDATA[7:0],
                           PWDATA[15:8]};
          st_nxt.cnt    = 3'h1;
        end
        fbas_pkg::HREG_SETUP: begin
          // access mode first, then class, then page
          st_nxt.ops[0] = {1'b1, fbas_pkg::CODE_PAS, PWDATA[7:0]};
          st_nxt.ops[1] = {1'b1, fbas_pkg::CODE_CLASS, PWDATA[15:8]};
          st_nxt.ops[2] = {1'b1, fbas_pkg::CODE_PAGE, PWDATA[23:16]};
          st_nxt.cnt    = 3'h3;
          // class skipped when only the page changes
          if (PWDATA[fbas_pkg::HSET_SKIP_BIT]) begin
            st_nxt.ops[1] = st_nxt.ops[2];
            st_nxt.cnt    = 3'h2;
          end
        end
        fbas_pkg::HREG_KEY: begin
          // both key words go out back to back
          // software supplies the words as stored, not swapped
          st_nxt.ops[0] = {1'b1, fbas_pkg::CODE_CTRL_LO, PWDATA[7:0]};
          st_nxt.ops[1] = {1'b1, fbas_pkg::CODE_CTRL_HI, PWDATA[15:8]};
          st_nxt.ops[2] = {1'b1, fbas_pkg::CODE_CTRL_LO, PWDATA[23:16]};
          st_nxt.ops[3] = {1'b1, fbas_pkg::CODE_CTRL_HI, PWDATA[31:24]};
          st_nxt.cnt    = 3'h4;
        end
        default: st_nxt.cnt = 3'h0;
      endcase
      if (st_nxt.cnt != 3'h0)
        st_nxt.state = HS_RUN;
    end
    // sequencer: one link request per cycle, reads wait
    case (st_r.state)
      HS_IDLE: ;
      HS_RUN: begin
        if (st_r.idx < st_r.cnt) begin
          st_nxt.req   = st_r.ops[st_r.idx[1:0]];
          st_nxt.req_v = 1'b1;
          st_nxt.idx   = st_r.idx + 3'h1;
          if (!st_nxt.req.wr)
            st_nxt.state = HS_WAIT;
          else if (st_nxt.req.code >= fbas_pkg::CODE_BUF &&
                   st_nxt.req.code <= fbas_pkg::CODE_BUF_LAST)
            st_nxt.shadow[st_nxt.req.code[4:0]] = st_nxt.req.data;
        end else begin
          st_nxt.state = HS_IDLE;
        end
      end
      HS_WAIT: begin
        if (LINK.rsp_valid) begin
          st_nxt.rdata = LINK.rsp_data;
          st_nxt.state = HS_RUN;
          if (st_r.req.code >= fbas_pkg::CODE_BUF &&
              st_r.req.code <= fbas_pkg::CODE_BUF_LAST)
            st_nxt.shadow[st_r.req.code[4:0]] = LINK.rsp_data;
        end
      end
      default: st_nxt.state = HS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r       <= '0;
      st_r.state <= HS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero wait state slave, never an error
  assign PREADY          = 1'b1;
  assign PSLVERR         = 1'b0;
  assign PRDATA          = st_r.prdata;
  assign LINK.req_valid  = st_r.req_v;
  assign LINK.req_write  = st_r.req.wr;
  assign LINK.req_code   = st_r.req.code;
  assign LINK.req_wdata  = st_r.req.data;
endmodule // fbas_host

// [test/fbas_link_properties.sv]
// checker for the link between the host and device ends
`timescale 1ns/100ps
module fbas_link_properties (
  input wire logic                   CLK,
  input wire logic                   RST_N,
  input wire logic                   req_valid,
  input wire logic                   req_write,
  input wire logic [7:0]             req_code,
  input wire logic                   rsp_valid,
  input wire fbas_pkg::fbas_sec_type SEC_STATE,
  input wire logic                   NV_COMMIT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // decoded link requests
  wire rd_req = req_valid && !req_write;
  wire wr_lo  = req_valid && req_write && req_code == fbas_pkg::CODE_CTRL_LO;
  wire wr_hi  = req_valid && req_write && req_code == fbas_pkg::CODE_CTRL_HI;
  wire wr_sum = req_valid && req_write && req_code == fbas_pkg::CODE_CSUM;
  property p_read_answer; rd_req |=> rsp_valid; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read request got no answer");
  property p_no_stray; !rd_req |=> !rsp_valid; endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("answer without a read request");
  property p_commit_cause; NV_COMMIT |-> $past(wr_sum); endproperty
  a_commit_cause: assert property (p_commit_cause)
    else $error("commit without a checksum write");
  // a commit cannot land in boot, since no page is writable there
  property p_boot_no_commit;
    NV_COMMIT |-> SEC_STATE != fbas_pkg::SEC_BOOT;
  endproperty
  a_boot_no_commit: assert property (p_boot_no_commit)
    else $error("commit while in boot");
  property p_boot_from_full;
    $changed(SEC_STATE) && SEC_STATE == fbas_pkg::SEC_BOOT
      |-> $past(SEC_STATE) == fbas_pkg::SEC_FULL;
  endproperty
  a_boot_from_full: assert property (p_boot_from_full)
    else $error("boot entered from a level below full");
  property p_full_from_unl;
    SEC_STATE == fbas_pkg::SEC_FULL && $past(SEC_STATE) != fbas_pkg::SEC_FULL
      |-> $past(SEC_STATE) == fbas_pkg::SEC_UNLOCKED;
  endproperty
  a_full_from_unl: assert property (p_full_from_unl)
    else $error("full access entered other than from unlocked");
  property p_level_by_hi; $changed(SEC_STATE) |-> $past(wr_hi); endproperty
  a_level_by_hi: assert property (p_level_by_hi)
    else $error("level changed without a control word");
  property p_lo_holds; wr_lo |=> $stable(SEC_STATE); endproperty
  a_lo_holds: assert property (p_lo_holds)
    else $error("level changed on a low control byte");
  c_commit: cover property (NV_COMMIT);
  c_boot: cover property (SEC_STATE == fbas_pkg::SEC_BOOT);
  c_unlock: cover property ($changed(SEC_STATE) &&
                            SEC_STATE == fbas_pkg::SEC_UNLOCKED);
endmodule // fbas_link_properties

// [test/tb_flash_block_access_security.sv]
// self-checking bench joining host and device ends over the link
`timescale 1ns/100ps
module tb_flash_block_access_security;
  localparam int NP  = 4;
  localparam int MIB = 232; // info block A, class 58 page 0
  localparam int KEY = 252; // key page, class 63 page 0
  localparam int DCP = 192; // direct read page, class 48 page 0
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   commit;
  fbas_pkg::fbas_sec_type sec;
  logic [31:0]            seed = 32'h37fd;
  logic [255:0]           pg [4];
  int                     errors = 0;
  int                     check_count = 0;
  int                     commits = 0;
  fbas_link_if link ();
  fbas_host i_fbas_host (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LINK(link.host));
  fbas_device #(.NV_PAGES(NP)) i_fbas_device (
    .CLK(clk), .RST_N(rst_n), .LINK(link.dev), .SEC_STATE(sec),
    .NV_COMMIT(commit));
  fbas_link_properties i_fbas_link_properties (
    .CLK(clk), .RST_N(rst_n), .req_valid(link.req_valid),
    .req_write(link.req_write), .req_code(link.req_code),
    .rsp_valid(link.rsp_valid), .SEC_STATE(sec), .NV_COMMIT(commit));
  // clock and a count of commit pulses
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (commit === 1'b1) commits <= commits + 1;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // checksum a host must send: base minus the page byte sum
  function automatic logic [7:0] csum(input logic [255:0] p);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 32; i++) s = s + p[8*i+:8];
    return fbas_pkg::CSUM_BASE - s;
  endfunction
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_sec(input fbas_pkg::fbas_sec_type exp);
    check_count++;
    if (sec !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, sec, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      complete_run();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll until the host has finished its link sequence
  task automatic idle(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, fbas_pkg::HREG_STATUS, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 40);
    if (n >= 40) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] d,
                     input logic w, output logic [7:0] rb);
    logic [31:0] st;
    apb(1'b1, fbas_pkg::HREG_CMD, {15'h0, w, d, c}, st);
    idle(st);
    rb = st[15:8];
  endtask
  task automatic ctrl(input logic [15:0] wd);
    logic [7:0] x;
    cmd(fbas_pkg::CODE_CTRL_LO, wd[7:0], 1'b1, x);
    cmd(fbas_pkg::CODE_CTRL_HI, wd[15:8], 1'b1, x);
  endtask
  task automatic key(input logic [15:0] w0, input logic [15:0] w1);
    logic [31:0] st;
    apb(1'b1, fbas_pkg::HREG_KEY, {w1, w0}, st);
    idle(st);
  endtask
  task automatic setup(input logic [7:0] pas, input logic [7:0] cls,
                       input logic [7:0] page, input logic skip);
    logic [31:0] st;
    apb(1'b1, fbas_pkg::HREG_SETUP, {7'h0, skip, page, cls, pas}, st);
    idle(st);
  endtask
  // send a checksum (optionally spoiled) and count the commits it caused
  task automatic commit_chk(input logic [255:0] p, input logic [7:0] flip,
                            input int exp);
    logic [7:0] x;
    int c0;
    c0 = commits;
    cmd(fbas_pkg::CODE_CSUM, csum(p) ^ flip, 1'b1, x);
    chk(commits - c0, exp);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    logic [7:0] b;
    logic [31:0] st;
    logic [255:0] p;
    logic [255:0] q;
    int k;
    // random pages
    // key low bytes avoid every subcommand code
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 8; j++) pg[i][32*j+:32] = rnd();
    end
    for (int j = 0; j < 4; j++) begin
      pg[3][16*j+:8] = (j < 2) ? 8'ha5 : 8'h5a;
      pg[3][16*j+15] = (j >= 2);
    end
    for (int i = 0; i < 3; i++) i_fbas_device.nv_mem[MIB+i] = pg[i];
    i_fbas_device.nv_mem[KEY] = pg[3];
    i_fbas_device.nv_mem[DCP] = pg[0];
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_sec(fbas_pkg::SEC_LOCKED);
    cmd(fbas_pkg::CODE_DCAP_LO, 8'h00, 1'b0, b);
    chk(b, pg[0][7:0]);
    cmd(fbas_pkg::CODE_CTRL_HI, 8'h00, 1'b0, b);
    chk(b[5], 32'h1);
    apb(1'b0, 8'h10, 32'h0, st);
    chk(st, 32'h0);
    chk(pslverr, 32'h0);
    // locked: blocks by page number, block A never written back
    for (int blk = 1; blk <= 3; blk++) begin
      setup(fbas_pkg::PAS_MIB, 8'h00, 8'(blk), 1'b1);
      k = int'(rnd() % 32);
      cmd(fbas_pkg::CODE_BUF + 8'(k), 8'h00, 1'b0, b);
      chk(b, pg[blk-1][8*k+:8]);
      p = pg[blk-1];
      p[8*k+:8] = ~b;
      cmd(fbas_pkg::CODE_BUF + 8'(k), p[8*k+:8], 1'b1, b);
      commit_chk(p, 8'h01, 0);
      commit_chk(p, 8'h00, blk > 1);
      if (blk > 1) pg[blk-1] = p;
      chk(i_fbas_device.nv_mem[MIB+blk-1][8*k+:8], pg[blk-1][8*k+:8]);
    end
    // broken then swapped key pairs leave it locked
    ctrl(pg[3][15:0]);
    ctrl(16'h0000);
    ctrl(pg[3][31:16]);
    chk_sec(fbas_pkg::SEC_LOCKED);
    key({pg[3][7:0], pg[3][15:8]}, {pg[3][23:16], pg[3][31:24]});
    chk_sec(fbas_pkg::SEC_LOCKED);
    key(pg[3][15:0], pg[3][31:16]);
    chk_sec(fbas_pkg::SEC_UNLOCKED);
    cmd(fbas_pkg::CODE_CTRL_HI, 8'h00, 1'b0, b);
    chk(b[5], 32'h0);
    cmd(fbas_pkg::CODE_FLAGS_HI, 8'h00, 1'b0, b);
    chk(b[6], 32'h1);
    ctrl(fbas_pkg::SUB_ROM);
    chk_sec(fbas_pkg::SEC_UNLOCKED);
    // short write: memory past the written length must survive
    setup(fbas_pkg::PAS_GENERAL, fbas_pkg::MIB_CLASS, 8'h00, 1'b0);
    cmd(fbas_pkg::CODE_BUF + 8'h1f, 8'h00, 1'b0, b);
    chk(b, pg[0][255:248]);
    p = pg[0];
    p[31:0] = rnd();
    for (int i = 0; i < 4; i++)
      cmd(fbas_pkg::CODE_BUF + 8'(i), p[8*i+:8], 1'b1, b);
    q = pg[0];
    q[255:248] = ~q[255:248];
    i_fbas_device.nv_mem[MIB] = q;
    commit_chk(p, 8'h00, 1);
    chk(i_fbas_device.nv_mem[MIB][31:0], p[31:0]);
    chk(i_fbas_device.nv_mem[MIB][255:224], q[255:224]);
    // key page: refused unlocked, accepted with full access
    setup(fbas_pkg::PAS_GENERAL, fbas_pkg::KEY_CLASS, 8'h00, 1'b0);
    p = pg[3];
    p[87:80] = ~p[87:80];
    cmd(fbas_pkg::CODE_BUF + 8'h0a, p[87:80], 1'b1, b);
    commit_chk(p, 8'h00, 0);
    key(pg[3][47:32], pg[3][63:48]);
    chk_sec(fbas_pkg::SEC_FULL);
    cmd(fbas_pkg::CODE_FLAGS_HI, 8'h00, 1'b0, b);
    chk(b[6], 32'h0);
    commit_chk(p, 8'h00, 1);
    ctrl(fbas_pkg::SUB_ROM);
    chk_sec(fbas_pkg::SEC_BOOT);
    cmd(fbas_pkg::CODE_BUF, 8'h00, 1'b0, b);
    chk(b, 32'h0);
    ctrl(fbas_pkg::SUB_ROM_EXIT);
    chk_sec(fbas_pkg::SEC_LOCKED);
    complete_run();
  end
endmodule // tb_flash_block_access_security
